// *** common/sysint_pkg.sv ***
// package: register map, field layout, timing and carrier types of the system integration unit
package sysint_pkg;

  // register word indices; the bus byte address is the index times four
  localparam logic [15:0] IDX_BREAK_WAIT   = 16'hfe00;
  localparam logic [15:0] IDX_LAST_RESET   = 16'hfe01;
  localparam logic [15:0] IDX_BREAK_CLEAR  = 16'hfe03;
  localparam logic [15:0] IDX_PEND_A       = 16'hfe04;
  localparam logic [15:0] IDX_PEND_B       = 16'hfe05;
  localparam logic [15:0] IDX_PEND_C       = 16'hfe06;
  localparam int          ADDR_W           = 18;

  // reset source flag positions in last_reset_source
  localparam int BIT_POWER_ON  = 7;
  localparam int BIT_PIN       = 6;
  localparam int BIT_WATCHDOG  = 5;
  localparam int BIT_BAD_OP    = 4;
  localparam int BIT_BAD_FETCH = 3;
  localparam int BIT_MONITOR   = 2;
  localparam int BIT_LOW_VOLT  = 1;

  // field positions
  localparam int BIT_CLEAR_ENABLE = 7;
  localparam int BIT_BREAK_WAIT   = 1;

  // reset values
  localparam logic [7:0] RST_BREAK_CLEAR = 8'h00;
  localparam logic [7:0] RST_LAST_RESET  = 8'h80;

  // stop recovery counts, in oscillator clock cycles
  localparam int STOP_LONG_CYC  = 4096;
  localparam int STOP_SHORT_CYC = 32;
  localparam int CNT_W          = 13;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // low-power sequencing states
  typedef enum logic [3:0] {
    ST_RUN     = 4'h1,
    ST_WAIT    = 4'h2,
    ST_STOP    = 4'h4,
    ST_RECOVER = 4'h8
  } power_state_t;

  // reset sources, one pulse per source
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch;
    logic monitor;
    logic low_voltage;
  } reset_src_t;

  // processor side events
  typedef struct packed {
    logic wait_exec;
    logic stop_exec;
    logic int_ack;
    logic mask_set;
  } cpu_evt_t;

endpackage : sysint_pkg

// *** rtl/sys_integration_unit.sv ***
// system integration unit: pending status, reset recording, break and low-power sequencing
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module sys_integration_unit #(
  parameter int NUM_SRC  = 20,
  parameter int LONG_CYC = sysint_pkg::STOP_LONG_CYC
) (
  // clock and reset
  input  wire  logic                     aclk,
  input  wire  logic                     aresetn,
  // axi4-lite write address and data
  input  wire  logic [17:0]              s_axi_awaddr,
  input  wire  logic                     s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire  logic [31:0]              s_axi_wdata,
  input  wire  logic [3:0]               s_axi_wstrb,
  input  wire  logic                     s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire  logic                     s_axi_bready,
  // axi4-lite read
  input  wire  logic [17:0]              s_axi_araddr,
  input  wire  logic                     s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire  logic                     s_axi_rready,
  // interrupt sources and processor events
  input  wire  logic [NUM_SRC-1:0]       irq_req,
  input  wire  logic [NUM_SRC-1:0]       irq_enable,
  input  wire  sysint_pkg::cpu_evt_t     cpu_evt,
  input  wire  logic                     cpu_mask,
  output logic                           mask_clear,
  output logic                           int_valid,
  output logic [4:0]                     int_vector_id,
  output logic                           stack_start,
  // break
  input  wire  logic                     break_req,
  input  wire  logic                     break_exit,
  output logic                           force_swi,
  output logic                           in_break,
  // peripheral flag clear gating
  input  wire  logic [NUM_SRC-1:0]       flag_clear_req,
  output logic [NUM_SRC-1:0]             flag_clear_ok,
  // resets and options
  input  wire  sysint_pkg::reset_src_t   reset_src,
  input  wire  logic                     short_recovery_option,
  input  wire  logic                     watchdog_disable_option,
  output logic                           sys_reset,
  // clocks and watchdog
  output logic                           cpu_clk_en,
  output logic                           bus_clock_en,
  output logic                           osc_clock_en,
  output logic                           watchdog_run,
  output logic [12:0]                    sys_count
);

  // short recovery count is fixed at 32 cycles; long one is a parameter for simulation
  localparam logic [12:0] SHORT_LIM = 13'(sysint_pkg::STOP_SHORT_CYC - 1);
  localparam logic [12:0] LONG_LIM  = 13'(LONG_CYC - 1);

  // state record, registered as one word:
  //   pstate        - low-power sequencing step
  //   count         - system counter; held at zero through stop, times recovery
  //   last_reset    - reset source flags, cleared by a read of the register
  //   clear_ctl     - break clear control; only the enable bit is kept
  //   break_wait_exit_flag - wait was left through a break
  //   brk, swi      - break state and its one-cycle vector force
  //   latched       - an interrupt is latched; latched_id names it
  //   stack         - one-cycle stacking start towards the core
  //   clr_pending   - read clear deferred one cycle past the data hand-off
  //   bvalid..rdata - bus answer registers, held until the master takes them
  //   two_step      - first step of a two-step clear seen from a peripheral
  typedef struct packed {
    sysint_pkg::power_state_t pstate;
    logic [12:0]              count;
    logic [7:0]               last_reset;
    logic [7:0]               clear_ctl;
    logic                     break_wait_exit_flag;
    logic                     brk;
    logic                     software_interrupt_vector;
    logic                     latched;
    logic [4:0]               latched_id;
    logic                     stack;
    logic                     clr_pending;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [31:0]              rdata;
    logic [NUM_SRC-1:0]       two_step;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // highest-priority pending enabled source: lowest index wins
  // the loop walks down so the lowest index is written last; it stays correct
  // for up to 32 sources, at the cost of a long priority chain
  function automatic logic [4:0] pick(input logic [NUM_SRC-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // word index decode shared by both channels
  function automatic logic [15:0] word_idx(input logic [17:0] a);
    return a[17:2];
  endfunction

  // helpers shared by the next-state logic and the bus outputs
  logic              any_reset;
  logic [NUM_SRC-1:0] live;
  logic              wr_go;
  logic              rd_go;

  // any reset source acts the same, no ordering among them
  assign any_reset = |reset_src;
  assign live      = irq_req & irq_enable;
  assign wr_go     = s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid;
  assign rd_go     = s_axi_arvalid && !state_reg.rvalid;

  // next-state logic: fields start from their registered value, pulses from zero;
  // later blocks may override earlier ones, so reset sources sit at the end
  always_comb begin
    state_next = state_reg;
    state_next.software_interrupt_vector   = 1'b0;
    state_next.stack = 1'b0;

    // reset recording: each source sets its own flag; power-on clears the rest
    // a source arriving in the clear cycle wins; one arriving after the flags were captured but before that cycle is lost
    // flags accumulate until read, since several sources may fire back to back
    if (state_reg.clr_pending) begin
      state_next.last_reset  = 8'h00;
      state_next.clr_pending = 1'b0;
    end
    if (any_reset) begin
      state_next.last_reset[sysint_pkg::BIT_PIN]       |= reset_src.pin;
      state_next.last_reset[sysint_pkg::BIT_WATCHDOG]  |= reset_src.watchdog;
      state_next.last_reset[sysint_pkg::BIT_BAD_OP]    |= reset_src.bad_opcode;
      state_next.last_reset[sysint_pkg::BIT_BAD_FETCH] |= reset_src.bad_fetch;
      state_next.last_reset[sysint_pkg::BIT_LOW_VOLT]  |= reset_src.low_voltage;
      state_next.last_reset[sysint_pkg::BIT_MONITOR]   |= reset_src.monitor;
      if (reset_src.power_on) begin
        state_next.last_reset = sysint_pkg::RST_LAST_RESET;
      end
    end

    // interrupt latch holds its choice until serviced, or until the core is unmasked with no enabled source pending
    // without the latch a late higher source could swap the vector mid-entry
    // a masked core latches nothing, so stale choices never reach it
    if (!state_reg.latched && !cpu_mask && |live) begin
      state_next.latched    = 1'b1;
      state_next.latched_id = pick(live);
    end else if (state_reg.latched && (cpu_evt.int_ack || !cpu_mask && !(|live))) begin
      state_next.latched = 1'b0;
    end

    // break entry forces the software vector; exit from wait flags it
    // a held break request enters once: the state bit guards re-entry
    if (break_req && !state_reg.brk) begin
      state_next.brk = 1'b1;
      state_next.software_interrupt_vector = 1'b1;
      if (state_reg.pstate == sysint_pkg::ST_WAIT) begin
        state_next.break_wait_exit_flag = 1'b1;
      end
    end else if (break_exit) begin
      state_next.brk = 1'b0;
    end

    // two-step clears: remember first step, hold second back during break
    for (int i = 0; i < NUM_SRC; i++) begin
      if (flag_clear_req[i]
          && !(state_reg.brk && !state_reg.clear_ctl[sysint_pkg::BIT_CLEAR_ENABLE])) begin
        state_next.two_step[i] = 1'b0;
      end else if (flag_clear_req[i]) begin
        state_next.two_step[i] = 1'b1;
      end
    end

    // low-power sequencing
    unique case (state_reg.pstate)
      // run: counter free-runs; stop takes precedence over wait
      sysint_pkg::ST_RUN: begin
        state_next.count = state_reg.count + 13'h0001;
        if (cpu_evt.stop_exec) begin
          state_next.pstate = sysint_pkg::ST_STOP;
          state_next.count  = 13'h0000;
        end else if (cpu_evt.wait_exec) begin
          state_next.pstate = sysint_pkg::ST_WAIT;
        end
      end
      // wait: peripherals run, any live source or a break wakes the core
      sysint_pkg::ST_WAIT: begin
        state_next.count = state_reg.count + 13'h0001;
        if (|live || break_req) begin
          state_next.pstate = sysint_pkg::ST_RUN;
          state_next.stack  = |live;
        end
      end
      // stop: everything halted, counter held at zero
      sysint_pkg::ST_STOP: begin
        state_next.count = 13'h0000;
        if (|live || break_req) begin
          state_next.pstate = sysint_pkg::ST_RECOVER;
        end
      end
      // recover: count the selected delay before stacking may begin
      sysint_pkg::ST_RECOVER: begin
        state_next.count = state_reg.count + 13'h0001;
        if (state_reg.count == (short_recovery_option ? SHORT_LIM : LONG_LIM)) begin
          state_next.pstate = sysint_pkg::ST_RUN;
          state_next.stack  = 1'b1;
        end
      end
    endcase

    // axi write: both channels together, response held until bready
    // limitation: a master that offers address and data apart waits for both
    // ready is withheld while an answer stands, so answers never overlap
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      state_next.bvalid = 1'b1;
      state_next.bresp  = sysint_pkg::RESP_OKAY;
      unique case (word_idx(s_axi_awaddr))
        sysint_pkg::IDX_BREAK_CLEAR: begin
          if (s_axi_wstrb[0]) begin
            state_next.clear_ctl = {s_axi_wdata[7], 7'h00};
          end
        end
        sysint_pkg::IDX_BREAK_WAIT: begin
          // software may only clear the flag; a new break event wins unless the flag is already set
          if (s_axi_wstrb[0] && !s_axi_wdata[sysint_pkg::BIT_BREAK_WAIT]
              && state_next.break_wait_exit_flag == state_reg.break_wait_exit_flag) begin
            state_next.break_wait_exit_flag = 1'b0;
          end
        end
        sysint_pkg::IDX_LAST_RESET, sysint_pkg::IDX_PEND_A,
        sysint_pkg::IDX_PEND_B, sysint_pkg::IDX_PEND_C: begin
          state_next.bresp = sysint_pkg::RESP_OKAY;
        end
        default: state_next.bresp = sysint_pkg::RESP_SLVERR;
      endcase
    end

    // axi read: data captured at acceptance
    // bit 31 of the held data marks a reset status read; it never leaves the block
    // the clear waits for the hand-off so the read itself still shows the flags
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
      if (state_reg.rdata[31]) begin
        state_next.clr_pending = 1'b1;
      end
      state_next.rdata = 32'h0000_0000;
    end
    if (rd_go) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = sysint_pkg::RESP_OKAY;
      state_next.rdata  = 32'h0000_0000;
      unique case (word_idx(s_axi_araddr))
        sysint_pkg::IDX_BREAK_WAIT:
          state_next.rdata[7:0] = {6'h00, state_reg.break_wait_exit_flag, 1'b0};
        sysint_pkg::IDX_LAST_RESET: begin
          state_next.rdata[7:0] = state_reg.last_reset;
          state_next.rdata[31]  = 1'b1;  // internal mark: clear after hand-off
        end
        sysint_pkg::IDX_BREAK_CLEAR: state_next.rdata[7:0] = state_reg.clear_ctl;
        sysint_pkg::IDX_PEND_A: state_next.rdata[7:0] = {irq_req[5:0], 2'b00};
        sysint_pkg::IDX_PEND_B: state_next.rdata[7:0] = irq_req[13:6];
        sysint_pkg::IDX_PEND_C: state_next.rdata[7:0] = {2'b00, irq_req[19:14]};
        default: state_next.rresp = sysint_pkg::RESP_SLVERR;
      endcase
    end

    // reset sources override the power state, the interrupt latch and the break state
    // all sources act alike here; only the recorded flags tell them apart
    // bus answers are left alone so a pending handshake still completes
    if (any_reset) begin
      state_next.pstate  = sysint_pkg::ST_RUN;
      state_next.latched = 1'b0;
      state_next.brk     = 1'b0;
    end
  end

  // one register for all state; reset restores power-on view
  // the bus reset counts as power-on, so the power-on flag reads set afterwards
  // reset is synchronous: the clock must run while it is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg            <= '0;
      state_reg.pstate     <= sysint_pkg::ST_RUN;
      state_reg.last_reset <= sysint_pkg::RST_LAST_RESET;
      state_reg.clear_ctl  <= sysint_pkg::RST_BREAK_CLEAR;
    end else begin
      state_reg <= state_next;
    end
  end

  // bus outputs; ready only when no answer is outstanding
  // ready is combinational on valid: a fast answer, at the cost of a longer path
  // the read-clear mark is masked off the visible data
  // the answer registers stand until the master takes them
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rresp   = state_reg.rresp;
  assign s_axi_rdata   = {1'b0, state_reg.rdata[30:0]};

  // processor and clock controls
  assign mask_clear    = cpu_evt.wait_exec || cpu_evt.stop_exec;
  assign int_valid     = state_reg.latched;
  assign int_vector_id = state_reg.latched_id;
  assign stack_start   = state_reg.stack;
  assign force_swi     = state_reg.software_interrupt_vector;
  assign in_break      = state_reg.brk;
  assign sys_reset     = any_reset;
  // wait gates only the core clock
  assign cpu_clk_en    = (state_reg.pstate == sysint_pkg::ST_RUN);
  // stop shuts both generator outputs; the oscillator restarts when recovery begins, the bus clock after it ends
  assign bus_clock_en  = (state_reg.pstate != sysint_pkg::ST_STOP)
                       && (state_reg.pstate != sysint_pkg::ST_RECOVER);
  assign osc_clock_en  = (state_reg.pstate != sysint_pkg::ST_STOP);
  assign watchdog_run  = !watchdog_disable_option
                       && (state_reg.pstate != sysint_pkg::ST_STOP);
  assign sys_count     = state_reg.count;

  // break blocks clears unless enabled; a pass goes through and stays done
  // the gate is purely combinational, so a peripheral sees it in the same cycle
  // the flags themselves live in the peripherals; only the permission is here
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      flag_clear_ok[i] = flag_clear_req[i]
                       && !(state_reg.brk
                            && !state_reg.clear_ctl[sysint_pkg::BIT_CLEAR_ENABLE]);
    end
  end

endmodule : sys_integration_unit

`default_nettype wire

// *** testbench/sysint_assertions.sv ***
// checker: timing relations on the system integration unit ports
`timescale 1ns/100ps
`default_nettype none
module sysint_assertions #(
  parameter int NUM_SRC = 20
) (
  // clock and reset
  input wire logic                   aclk,
  input wire logic                   aresetn,
  // processor and reset side
  input wire sysint_pkg::cpu_evt_t   cpu_evt,
  input wire sysint_pkg::reset_src_t reset_src,
  input wire logic                   mask_clear,
  input wire logic                   sys_reset,
  input wire logic                   int_valid,
  input wire logic [4:0]             int_vector_id,
  // clocks and watchdog
  input wire logic                   cpu_clk_en,
  input wire logic                   bus_clock_en,
  input wire logic                   osc_clock_en,
  input wire logic                   watchdog_run,
  input wire logic                   watchdog_disable_option,
  input wire logic [12:0]            sys_count,
  // break and flag gating
  input wire logic                   in_break,
  input wire logic                   force_swi,
  input wire logic [NUM_SRC-1:0]     flag_clear_req,
  input wire logic [NUM_SRC-1:0]     flag_clear_ok
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // sleep entry must drop the mask or the waking source could not be latched
  a_sleep_mask: assert property ((cpu_evt.wait_exec || cpu_evt.stop_exec) |-> mask_clear)
    else $error("mask not cleared on sleep entry");
  a_reset_equal: assert property (sys_reset == (|reset_src))
    else $error("reset output differs from source or");
  a_stop_clocks_off: assert property (!osc_clock_en |-> !bus_clock_en && !cpu_clk_en)
    else $error("clock left running in stop");
  a_stop_count_held: assert property (!osc_clock_en |-> sys_count == 13'h0)
    else $error("counter not held during stop");
  a_watchdog_wait: assert property ((!watchdog_disable_option && !cpu_clk_en && bus_clock_en)
    |-> watchdog_run)
    else $error("watchdog stopped in wait");
  a_clear_outside: assert property (!in_break |-> flag_clear_ok == flag_clear_req)
    else $error("flag clear blocked outside break");
  a_clear_in_break: assert property (in_break |-> (flag_clear_ok & ~flag_clear_req) == '0)
    else $error("unrequested flag clear in break");
  a_swi_pulse: assert property (force_swi |=> !force_swi && in_break)
    else $error("vector force not a single pulse into break");
  // a latched source keeps its id until serviced or the mask drops
  a_latch_hold: assert property ((int_valid && $past(int_valid) && !$past(cpu_evt.int_ack)
    && !$past(mask_clear)) |-> $stable(int_vector_id))
    else $error("latched interrupt preempted");
endmodule // sysint_assertions

bind sys_integration_unit sysint_assertions #(.NUM_SRC(NUM_SRC)) i_sysint_assertions (.*);
`default_nettype wire

// *** testbench/sysint_partner.sv ***
// partner model: processor core acknowledging interrupts and tracking its mask bit
`timescale 1ns/100ps
`default_nettype none
module sysint_partner (
  // clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // requests from the bench and the unit
  input  wire logic           do_wait,
  input  wire logic           do_stop,
  input  wire logic [3:0]     ack_dly,
  input  wire logic           stack_start,
  input  wire logic           mask_clear,
  // processor side
  output sysint_pkg::cpu_evt_t cpu_evt,
  output logic                cpu_mask
);
  logic [3:0] cnt;
  logic       pend;
  logic       ack;

  // ack comes ack_dly+1 cycles after the stacking pulse, so slow and prompt cores are both seen
  assign ack = pend && (cnt == 4'h0);
  assign cpu_evt = '{wait_exec: do_wait, stop_exec: do_stop, int_ack: ack, mask_set: ack};

  // mask starts set, as after reset; interrupt entry sets it again
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt      <= 4'h0;
      pend     <= 1'b0;
      cpu_mask <= 1'b1;
    end else begin
      if (stack_start) begin
        pend <= 1'b1;
        cnt  <= ack_dly;
      end else if (ack) begin
        pend <= 1'b0;
      end else if (pend) begin
        cnt <= cnt - 4'h1;
      end
      if (ack) begin
        cpu_mask <= 1'b1;
      end else if (mask_clear) begin
        cpu_mask <= 1'b0;
      end
    end
  end
endmodule // sysint_partner
`default_nettype wire

// *** testbench/sys_integration_unit_test.sv ***
// testbench: register, break, wait and stop sequences of the system integration unit
`timescale 1ns/100ps
`default_nettype none
module sys_integration_unit_test;
  localparam logic [17:0] A_BW = 18'h3f800;
  localparam logic [17:0] A_LR = 18'h3f804;
  localparam logic [17:0] A_BC = 18'h3f80c;
  localparam logic [17:0] A_PA = 18'h3f810;
  localparam logic [17:0] A_PB = 18'h3f814;
  localparam logic [17:0] A_PC = 18'h3f818;
  localparam logic [19:0] P    = 20'h5a3c9;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mask_clear;
  logic int_valid, stack_start, break_req, break_exit, force_swi, in_break, sys_reset;
  logic short_recovery_option, watchdog_disable_option, cpu_clk_en, bus_clock_en;
  logic osc_clock_en, watchdog_run, cpu_mask, do_wait, do_stop;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, ack_dly;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [19:0] irq_req, irq_enable, flag_clear_req, flag_clear_ok;
  logic [4:0]  int_vector_id;
  logic [12:0] sys_count;
  sysint_pkg::cpu_evt_t   cpu_evt;
  sysint_pkg::reset_src_t reset_src;
  int err_count = 0;
  int total_checks = 0;
  int n;

  // long recovery shortened to keep the run brief
  sys_integration_unit #(.LONG_CYC(64)) i_sys_integration_unit (.*);
  sysint_partner i_sysint_partner (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t: got %h want %h", $time, s, e);
    end
  endtask

  // ready is sampled mid-cycle, where it cannot race the launching edge
  task automatic wr(input logic [17:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(negedge aclk);
    while (!(s_axi_awready && s_axi_wready)) @(negedge aclk);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(negedge aclk);
    while (!s_axi_bvalid) @(negedge aclk);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(negedge aclk);
    while (!s_axi_arready) @(negedge aclk);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(negedge aclk);
    while (!s_axi_rvalid) @(negedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [17:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask

  // counts cycles until the vector force (swi=1) or stacking pulse appears
  task automatic wt(input logic software_interrupt_vector);
    n = 0;
    @(negedge aclk);
    while (!(software_interrupt_vector ? force_swi : stack_start) && n < 5000) begin
      @(negedge aclk);
      n++;
    end
  endtask

  task automatic sig(input int which);
    @(posedge aclk);
    case (which)
      0: do_wait <= 1'b1;
      1: do_stop <= 1'b1;
      default: break_exit <= 1'b1;
    endcase
    @(posedge aclk);
    {do_wait, do_stop, break_exit} <= 3'h0;
  endtask

  task print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100us;
    err_count++;
    print_verdict();
  end

  initial begin
    aresetn = 1'b0;
    s_axi_wstrb = 4'hf;
    ack_dly = 4'h8;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, break_req,
     break_exit, short_recovery_option, watchdog_disable_option, do_wait, do_stop, s_axi_awaddr,
     s_axi_araddr, s_axi_wdata, irq_req, irq_enable, flag_clear_req, reset_src} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(A_LR, 32'h80);
    rc(A_LR, 32'h00);
    rc(A_BC, 32'h00);
    rc(A_BW, 32'h00);
    // each source but power-on alone, then all at once with power-on among them
    for (int i = 0; i < 7; i++) begin
      @(posedge aclk);
      reset_src <= (i < 6) ? 7'(1 << i) : 7'h7f;
      @(negedge aclk);
      chk(sys_reset, 1);
      @(posedge aclk);
      reset_src <= '0;
      rc(A_LR, (i < 6) ? 32'(2 << i) : 32'h80);
    end
    irq_req <= P;
    rc(A_PA, {24'h0, P[5:0], 2'b00});
    rc(A_PB, {24'h0, P[13:6]});
    rc(A_PC, {26'h0, P[19:14]});
    wr(A_PA, 8'hff);
    chk(r, sysint_pkg::RESP_OKAY);
    rc(A_PA, {24'h0, P[5:0], 2'b00});
    rd(18'h3f808);
    chk(r, sysint_pkg::RESP_SLVERR);
    irq_req <= '0;
    // break with clears blocked, then enabled, then blocked, then after exit
    break_req <= 1'b1;
    wt(1'b1);
    chk(n < 3, 1);
    @(posedge aclk);
    break_req <= 1'b0;
    flag_clear_req <= 20'h00f0f;
    @(negedge aclk);
    chk(in_break, 1);
    chk(flag_clear_ok, 0);
    wr(A_BC, 8'h80);
    rc(A_BC, 32'h80);
    chk(flag_clear_ok, 20'h00f0f);
    wr(A_BC, 8'h00);
    chk(flag_clear_ok, 0);
    sig(2);
    @(negedge aclk);
    chk(in_break, 0);
    chk(flag_clear_ok, 20'h00f0f);
    flag_clear_req <= '0;
    // wait mode, woken by two sources; a later higher one must not preempt
    irq_enable <= '1;
    sig(0);
    @(negedge aclk);
    chk(cpu_clk_en, 0);
    chk(bus_clock_en, 1);
    chk(watchdog_run, 1);
    chk(cpu_mask, 0);
    @(posedge aclk);
    irq_req <= 20'h00088;
    wt(1'b0);
    chk(n <= 2, 1);
    chk(int_vector_id, 5'h3);
    chk(int_valid, 1);
    @(posedge aclk);
    irq_req <= 20'h00089;
    @(negedge aclk);
    chk(cpu_clk_en, 1);
    chk(int_vector_id, 5'h3);
    repeat (12) @(posedge aclk);
    irq_req <= '0;
    // break ends wait and leaves its mark
    sig(0);
    break_req <= 1'b1;
    wt(1'b1);
    @(posedge aclk);
    break_req <= 1'b0;
    rc(A_BW, 32'h02);
    wr(A_BW, 8'h00);
    rc(A_BW, 32'h00);
    sig(2);
    // stop with long then short recovery, prompt acknowledge
    ack_dly <= 4'h0;
    for (int k = 0; k < 2; k++) begin
      short_recovery_option <= (k == 1);
      sig(1);
      @(negedge aclk);
      chk(osc_clock_en, 0);
      chk(bus_clock_en, 0);
      chk(sys_count, 0);
      @(posedge aclk);
      irq_req <= 20'h00001;
      wt(1'b0);
      chk(n >= (k ? 32 : 64) && n <= (k ? 40 : 72), 1);
      @(posedge aclk);
      irq_req <= '0;
      repeat (4) @(posedge aclk);
    end
    // the disable option stops the watchdog
    watchdog_disable_option <= 1'b1;
    @(negedge aclk);
    chk(watchdog_run, 0);
    print_verdict();
  end
endmodule // sys_integration_unit_test
`default_nettype wire
